// ==== core/usb_cmd_pkg.sv ====
// constants, types and helpers for the command and status register block
// assumes a 250 MHz controller clock and a 32-bit APB register port
package usb_cmd_pkg;

    // ==========================================================
    // bus geometry
    localparam int ADDR_W = 8; // byte address width seen by the slave
    localparam int DATA_W = 32; // APB data width
    localparam int STRB_W = 4; // byte strobes

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] CMD_STATUS_OFF = 8'h00; // command_status
    localparam logic [7:0] CTRL_AUX_OFF = 8'h04; // functional state, routing, mask
    localparam logic [7:0] EVT_STATUS_OFF = 8'h08; // event_status, write one to clear

    // ==========================================================
    // command_status fields
    localparam int SOFT_RESET_BIT = 0; // soft_reset_request
    localparam int CTRL_PEND_BIT = 1; // control_list_pending
    localparam int BULK_PEND_BIT = 2; // bulk_list_pending
    localparam int OWN_REQ_BIT = 3; // ownership_request
    localparam int OVR_CNT_LSB = 16; // overrun counter, bits 17:16
    localparam int OVR_CNT_W = 2; // counter width

    // ==========================================================
    // control_aux fields
    localparam int FSTATE_LSB = 0; // functional_state_field, bits 1:0
    localparam int ROUTING_BIT = 2; // irq_routing_select
    localparam int OWN_EN_BIT = 3; // owner change event enable

    // ==========================================================
    // event_status fields
    localparam int OWN_FLAG_BIT = 0; // owner_change_flag
    localparam int OVR_FLAG_BIT = 1; // overrun_flag

    // ==========================================================
    // reset values
    localparam logic [OVR_CNT_W-1:0] OVR_CNT_RESET = 2'h0; // counter starts at 00b
    localparam logic [OVR_CNT_W-1:0] OVR_CNT_ONE = 2'h1; // increment step
    localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0; // unmapped and reserved read value

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 4; // controller clock period
    localparam int SOFT_RESET_LIMIT_US = 10; // longest soft reset time
    localparam int SOFT_RESET_LIMIT_CYCLES = (SOFT_RESET_LIMIT_US * 1000) / CLK_PERIOD_NS; // rounded down
    localparam int SOFT_RESET_HOLD_CYCLES = 16; // time spent clearing, well under the limit
    localparam int HOLD_CNT_W = 5; // width of the hold counter
    localparam logic [HOLD_CNT_W-1:0] HOLD_LAST = 5'(SOFT_RESET_HOLD_CYCLES - 1);
    localparam logic [HOLD_CNT_W-1:0] HOLD_ZERO = 5'h0;
    localparam logic [HOLD_CNT_W-1:0] HOLD_ONE = 5'h1;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        FS_RESET = 2'b00,
        FS_RESUME = 2'b01,
        FS_OPERATIONAL = 2'b10,
        FS_SUSPEND = 2'b11
    } fstate_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_CLEAR = 2'b01,
        SEQ_WAIT = 2'b10
    } seq_state_t;

    // ==========================================================
    // true when a write carries a one in bit pos with its byte lane enabled
    function automatic logic wr_one(input logic [DATA_W-1:0] data, input logic [STRB_W-1:0] strb,
                                    input int pos);
        wr_one = data[pos] & strb[pos / 8];
    endfunction

endpackage

// ==== core/list_pending_tracker.sv ====
// pending flag and run state for one descriptor list (control or bulk)
// assumes one-cycle pulses from the list engine and from the register decode
`timescale 1ns/100ps
module list_pending_tracker (
    input wire logic clk,
    input wire logic reset,
    input wire logic sw_set, // software wrote one to the pending bit
    input wire logic head, // engine at the head of the list
    input wire logic td_found, // engine found a transfer descriptor
    input wire logic list_end, // engine reached the end of the list
    input wire logic clear, // soft reset in progress
    output logic pending_ff,
    output logic running_ff
);
    import usb_cmd_pkg::*;

    // ==========================================================
    // pending flag
    // software set beats the hardware clear in the same cycle, so no
    // descriptor added during the head check is ever forgotten
    always_ff @(posedge clk) begin
        if (reset || clear) begin
            pending_ff <= 1'b0;
        end else if (sw_set) begin
            pending_ff <= 1'b1;
        end else if (running_ff && td_found) begin
            pending_ff <= 1'b1; // R9 R13
        end else if (head && pending_ff) begin
            pending_ff <= 1'b0; // R8 R12
        end
    end

    // ==========================================================
    // run state
    always_ff @(posedge clk) begin
        if (reset || clear) begin
            running_ff <= 1'b0;
        end else if (head) begin
            running_ff <= pending_ff; // R7 R8 R11 R12
        end else if (list_end) begin
            running_ff <= pending_ff; // R9 R13
        end
    end

endmodule // list_pending_tracker

// ==== core/soft_reset_sequencer.sv ====
// timed sequence for the controller soft reset
// assumes start is a one-cycle pulse that only comes while idle
`timescale 1ns/100ps
module soft_reset_sequencer (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    output logic busy,
    output logic done_ff
);
    import usb_cmd_pkg::*;

    seq_state_t state_ff; // sequence state
    seq_state_t nxt_state;
    logic [HOLD_CNT_W-1:0] hold_ff; // cycles spent waiting

    // ==========================================================
    // next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SEQ_IDLE: begin
                if (start) begin
                    nxt_state = SEQ_CLEAR;
                end
            end
            SEQ_CLEAR: begin
                nxt_state = SEQ_WAIT;
            end
            SEQ_WAIT: begin
                if (hold_ff == HOLD_LAST) begin
                    nxt_state = SEQ_IDLE; // R4
                end
            end
            default: begin
                nxt_state = SEQ_IDLE;
            end
        endcase
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= SEQ_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // hold counter, bounded so the whole reset stays short
    always_ff @(posedge clk) begin
        if (reset || state_ff != SEQ_WAIT) begin
            hold_ff <= HOLD_ZERO;
        end else begin
            hold_ff <= hold_ff + HOLD_ONE;
        end
    end

    // ==========================================================
    // completion pulse
    always_ff @(posedge clk) begin
        if (reset) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= (state_ff == SEQ_WAIT) && (nxt_state == SEQ_IDLE);
        end
    end

    assign busy = (state_ff != SEQ_IDLE);

endmodule // soft_reset_sequencer

// ==== core/usb_host_command_status.sv ====
// command and status register of a USB host controller, with APB slave
// assumes the list engine, overrun detector and handover logic give one-cycle pulses
// How it works
// [R1] driver writes one to request soft reset
// [R2] soft reset enters suspend, keeps routing
// [R3] no host bus access while soft reset suspended
// [R4] reset bit self-clears, done within 10 us
// [R5] soft reset never resets root hub
// [R6] driver sets control pending per new descriptor
// [R7] control pending zero: control list not started
// [R8] control pending one: start, clear bit
// [R9] found descriptor re-sets control pending bit
// [R10] driver sets bulk pending per new descriptor
// [R11] bulk pending zero: bulk list not started
// [R12] bulk pending one: start, clear bit
// [R13] found descriptor re-sets bulk pending bit
// [R14] ownership request raises owner change flag
// [R15] request clears after handover, stays clear
// [R16] two-bit overrun counter, wraps after three
// [R17] counter counts even with flag set
// [R18] functional states; suspend is 11b
// [R19] unmasked owner change gives immediate management irq
// [R20] command_status bit layout, others read zero
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module usb_host_command_status (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [usb_cmd_pkg::ADDR_W-1:0] PADDR,
    input wire logic [usb_cmd_pkg::DATA_W-1:0] PWDATA,
    input wire logic [usb_cmd_pkg::STRB_W-1:0] PSTRB,
    output logic [usb_cmd_pkg::DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic CTRL_HEAD,
    input wire logic CTRL_TD_FOUND,
    input wire logic CTRL_LIST_END,
    output logic CTRL_RUN,
    input wire logic BULK_HEAD,
    input wire logic BULK_TD_FOUND,
    input wire logic BULK_LIST_END,
    output logic BULK_RUN,
    input wire logic OVERRUN,
    input wire logic OWNER_HANDOVER_DONE,
    output logic OWNER_CHANGE_FLAG,
    output logic SYSTEM_MGMT_IRQ,
    output logic IRQ_ROUTING,
    output logic [1:0] FUNCTIONAL_STATE,
    output logic HOST_BUS_ENABLE,
    output logic ROOT_HUB_RESET,
    output logic OPS_CLEAR
);
    import usb_cmd_pkg::*;

    // twice the hold time: far inside the 10 us limit, and short enough for a delay range
    localparam int reset_limit_cyc = SOFT_RESET_HOLD_CYCLES + SOFT_RESET_HOLD_CYCLES;

    // ==========================================================
    // declarations
    logic soft_reset_ff; // soft_reset_request bit
    logic own_req_ff; // ownership_request bit
    logic own_flag_ff; // owner_change_flag
    logic own_en_ff; // owner change event enable
    logic ovr_flag_ff; // overrun_flag
    logic [OVR_CNT_W-1:0] ovr_cnt_ff; // scheduling overrun counter
    fstate_t fstate_ff; // functional_state_field
    logic routing_ff; // irq_routing_select
    logic smi_ff; // management interrupt
    logic bus_en_ff; // host bus access permitted
    logic hub_rst_ff; // root hub reset, hardware reset only
    logic [DATA_W-1:0] prdata_ff; // read data captured in setup
    logic ctrl_pend, ctrl_run, bulk_pend, bulk_run;
    logic sr_busy, sr_done;
    logic access, wr_en, wr_cmd, wr_aux, wr_evt;
    logic sr_start, ctrl_set, bulk_set, own_set;

    // ==========================================================
    // address decode
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = (a == CMD_STATUS_OFF) || (a == CTRL_AUX_OFF) || (a == EVT_STATUS_OFF);
    endfunction

    // ==========================================================
    // APB strobes: zero wait states, write lands at the access edge
    assign access = PSEL && PENABLE;
    assign wr_en = access && PWRITE && addr_mapped(PADDR);
    assign wr_cmd = wr_en && (PADDR == CMD_STATUS_OFF);
    assign wr_aux = wr_en && (PADDR == CTRL_AUX_OFF);
    assign wr_evt = wr_en && (PADDR == EVT_STATUS_OFF);
    assign PREADY = 1'b1;
    assign PSLVERR = access && !addr_mapped(PADDR);

    // software set strobes; writing zero to these bits has no effect
    assign sr_start = wr_cmd && wr_one(PWDATA, PSTRB, SOFT_RESET_BIT) && !soft_reset_ff; // R1
    assign ctrl_set = wr_cmd && wr_one(PWDATA, PSTRB, CTRL_PEND_BIT) && !sr_busy; // R6
    assign bulk_set = wr_cmd && wr_one(PWDATA, PSTRB, BULK_PEND_BIT) && !sr_busy; // R10
    assign own_set = wr_cmd && wr_one(PWDATA, PSTRB, OWN_REQ_BIT) && !sr_busy; // R14

    // ==========================================================
    // read data, captured in the setup cycle so PRDATA comes from a flop
    always_ff @(posedge CLK) begin
        if (RESET) begin
            prdata_ff <= RDATA_ZERO;
        end else if (PSEL && !PENABLE) begin
            prdata_ff <= RDATA_ZERO;
            case (PADDR)
                CMD_STATUS_OFF: begin
                    prdata_ff[SOFT_RESET_BIT] <= soft_reset_ff; // R20
                    prdata_ff[CTRL_PEND_BIT] <= ctrl_pend;
                    prdata_ff[BULK_PEND_BIT] <= bulk_pend;
                    prdata_ff[OWN_REQ_BIT] <= own_req_ff;
                    prdata_ff[OVR_CNT_LSB +: OVR_CNT_W] <= ovr_cnt_ff;
                end
                CTRL_AUX_OFF: begin
                    prdata_ff[FSTATE_LSB +: 2] <= fstate_ff;
                    prdata_ff[ROUTING_BIT] <= routing_ff;
                    prdata_ff[OWN_EN_BIT] <= own_en_ff;
                end
                EVT_STATUS_OFF: begin
                    prdata_ff[OWN_FLAG_BIT] <= own_flag_ff;
                    prdata_ff[OVR_FLAG_BIT] <= ovr_flag_ff;
                end
                default: begin
                    prdata_ff <= RDATA_ZERO; // unmapped reads zero with an error
                end
            endcase
        end
    end

    // ==========================================================
    // soft reset request bit: set by software, cleared by the sequencer
    always_ff @(posedge CLK) begin
        if (RESET) begin
            soft_reset_ff <= 1'b0;
        end else if (sr_start) begin
            soft_reset_ff <= 1'b1; // R1
        end else if (sr_done) begin
            soft_reset_ff <= 1'b0; // R4
        end
    end

    soft_reset_sequencer u_seq (
        .clk(CLK),
        .reset(RESET),
        .start(sr_start),
        .busy(sr_busy),
        .done_ff(sr_done)
    );

    // clear level to the other operational registers of the controller, held while the sequencer is busy
    assign OPS_CLEAR = sr_busy; // R2

    // ==========================================================
    // list pending trackers
    list_pending_tracker u_ctrl (
        .clk(CLK),
        .reset(RESET),
        .sw_set(ctrl_set),
        .head(CTRL_HEAD),
        .td_found(CTRL_TD_FOUND),
        .list_end(CTRL_LIST_END),
        .clear(sr_busy),
        .pending_ff(ctrl_pend),
        .running_ff(ctrl_run)
    );

    list_pending_tracker u_bulk (
        .clk(CLK),
        .reset(RESET),
        .sw_set(bulk_set),
        .head(BULK_HEAD),
        .td_found(BULK_TD_FOUND),
        .list_end(BULK_LIST_END),
        .clear(sr_busy),
        .pending_ff(bulk_pend),
        .running_ff(bulk_run)
    );

    assign CTRL_RUN = ctrl_run;
    assign BULK_RUN = bulk_run;

    // ==========================================================
    // ownership request, cleared once the handover is complete
    always_ff @(posedge CLK) begin
        if (RESET || sr_busy) begin
            own_req_ff <= 1'b0;
        end else if (own_set) begin
            own_req_ff <= 1'b1; // R14
        end else if (OWNER_HANDOVER_DONE) begin
            own_req_ff <= 1'b0; // R15
        end
    end

    // owner change flag: hardware set beats a software clear
    always_ff @(posedge CLK) begin
        if (RESET || sr_busy) begin
            own_flag_ff <= 1'b0;
        end else if (own_req_ff) begin
            own_flag_ff <= 1'b1; // R14
        end else if (wr_evt && wr_one(PWDATA, PSTRB, OWN_FLAG_BIT)) begin
            own_flag_ff <= 1'b0;
        end
    end

    // management interrupt, one cycle after an unmasked flag
    always_ff @(posedge CLK) begin
        if (RESET) begin
            smi_ff <= 1'b0;
        end else begin
            smi_ff <= own_flag_ff && own_en_ff; // R19
        end
    end

    // ==========================================================
    // overrun counter and flag; the counter ignores the flag state
    always_ff @(posedge CLK) begin
        if (RESET || sr_busy) begin
            ovr_cnt_ff <= OVR_CNT_RESET; // R16
        end else if (OVERRUN) begin
            ovr_cnt_ff <= ovr_cnt_ff + OVR_CNT_ONE; // R16 R17
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET || sr_busy) begin
            ovr_flag_ff <= 1'b0;
        end else if (OVERRUN) begin
            ovr_flag_ff <= 1'b1;
        end else if (wr_evt && wr_one(PWDATA, PSTRB, OVR_FLAG_BIT)) begin
            ovr_flag_ff <= 1'b0;
        end
    end

    // ==========================================================
    // control_aux: functional state, routing, event enable
    always_ff @(posedge CLK) begin
        if (RESET) begin
            fstate_ff <= FS_RESET;
        end else if (sr_busy) begin
            fstate_ff <= FS_SUSPEND; // R2 R18
        end else if (wr_aux && PSTRB[0]) begin
            fstate_ff <= fstate_t'(PWDATA[FSTATE_LSB +: 2]);
        end
    end

    // routing survives a soft reset, only hardware reset or a software write clears it
    always_ff @(posedge CLK) begin
        if (RESET) begin
            routing_ff <= 1'b0;
        end else if (wr_aux && PSTRB[0]) begin
            routing_ff <= PWDATA[ROUTING_BIT]; // R2
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET || sr_busy) begin
            own_en_ff <= 1'b0;
        end else if (wr_aux && PSTRB[0]) begin
            own_en_ff <= PWDATA[OWN_EN_BIT];
        end
    end

    // ==========================================================
    // host bus permission: registered, so it drops the cycle after a reset starts or suspend is entered
    always_ff @(posedge CLK) begin
        if (RESET) begin
            bus_en_ff <= 1'b0;
        end else begin
            bus_en_ff <= (fstate_ff == FS_OPERATIONAL) && !sr_busy && !soft_reset_ff; // R3
        end
    end

    // root hub reset follows the hardware reset alone
    always_ff @(posedge CLK) begin
        if (RESET) begin
            hub_rst_ff <= 1'b1;
        end else begin
            hub_rst_ff <= 1'b0; // R5
        end
    end

    // ==========================================================
    // outputs
    assign PRDATA = prdata_ff;
    assign OWNER_CHANGE_FLAG = own_flag_ff;
    assign SYSTEM_MGMT_IRQ = smi_ff;
    assign IRQ_ROUTING = routing_ff;
    assign FUNCTIONAL_STATE = fstate_ff;
    assign HOST_BUS_ENABLE = bus_en_ff;
    assign ROOT_HUB_RESET = hub_rst_ff;

    // ==========================================================
    // checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    soft_clr_bound_a: assert property (soft_reset_ff |-> ##[1:reset_limit_cyc] !soft_reset_ff) // R4
        else $error("soft reset bit not cleared in time");
    suspend_entry_a: assert property ($fell(soft_reset_ff) |-> fstate_ff == FS_SUSPEND) // R2 R18
        else $error("soft reset did not end in suspend");
    routing_kept_a: assert property ((sr_busy && !wr_aux) |=> $stable(routing_ff)) // R2
        else $error("routing changed by soft reset");
    no_bus_a: assert property ((sr_busy || soft_reset_ff) |=> !HOST_BUS_ENABLE) // R3
        else $error("host bus enabled during soft reset");
    hub_quiet_a: assert property (sr_busy |-> !ROOT_HUB_RESET) // R5
        else $error("root hub reset by soft reset");
    ctrl_hold_a: assert property ((CTRL_HEAD && !ctrl_pend && !sr_busy) |=> !ctrl_run) // R7
        else $error("control list started while not pending");
    ctrl_start_a: assert property ((CTRL_HEAD && ctrl_pend && !ctrl_set && !sr_busy
                                    && !(ctrl_run && CTRL_TD_FOUND)) |=> (ctrl_run && !ctrl_pend)) // R8
        else $error("control list did not start and clear");
    ctrl_refill_a: assert property ((ctrl_run && CTRL_TD_FOUND && !sr_busy) |=> ctrl_pend) // R9
        else $error("control pending not re-set");
    bulk_hold_a: assert property ((BULK_HEAD && !bulk_pend && !sr_busy) |=> !bulk_run) // R11
        else $error("bulk list started while not pending");
    bulk_start_a: assert property ((BULK_HEAD && bulk_pend && !bulk_set && !sr_busy
                                    && !(bulk_run && BULK_TD_FOUND)) |=> (bulk_run && !bulk_pend)) // R12
        else $error("bulk list did not start and clear");
    bulk_refill_a: assert property ((bulk_run && BULK_TD_FOUND && !sr_busy) |=> bulk_pend) // R13
        else $error("bulk pending not re-set");
    owner_flag_a: assert property ((own_req_ff && !sr_busy) |=> own_flag_ff ##1 own_flag_ff || sr_busy) // R14
        else $error("owner change flag not raised");
    owner_hold_a: assert property ((own_req_ff && !OWNER_HANDOVER_DONE && !sr_busy) |=> own_req_ff) // R15
        else $error("ownership request dropped early");
    smi_raise_a: assert property ((own_flag_ff && own_en_ff) |=> SYSTEM_MGMT_IRQ) // R19
        else $error("management irq not raised");
    overrun_cnt_a: assert property ((OVERRUN && !sr_busy) |=> ovr_cnt_ff == 2'($past(ovr_cnt_ff) + OVR_CNT_ONE)) // R16 R17
        else $error("overrun counter did not step");

endmodule // usb_host_command_status

// ==== verif/host_driver_model.sv ====
// apb master standing in for the driver software on the host processor
// assumes a slave on clk that may add wait states through pready
`timescale 1ns/100ps
module host_driver_model (
    input wire logic clk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb
);
    logic [31:0] rdata; // data taken at the answering edge
    logic err; // slave error taken at the same edge
    // ==========================================================
    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
    end
    // ==========================================================
    // one transfer; request held until pready seen, no assumed latency
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // host_driver_model

// ==== verif/tb_top.sv ====
// self-checking bench for the command and status register block
// assumes the apb master model and a 250 MHz clock
`timescale 1ns/100ps
module tb_top;
    import usb_cmd_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] ev = 8'h00; // engine pulses: ctrl 0..2, bulk 3..5, overrun 6, handover 7
    logic psel, penable, pwrite, pready, pslverr, flag, system_mgmt_irq, rout, hbe, rhr, opc;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, b;
    logic [3:0] pstrb;
    logic [1:0] run, fs;
    int n_fail = 0;
    int samples_checked = 0;
    int n, o;
    // ==========================================================
    // clock and instances
    initial forever #2 clk = ~clk;
    host_driver_model host (.clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
    usb_host_command_status dut (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CTRL_HEAD(ev[0]), .CTRL_TD_FOUND(ev[1]), .CTRL_LIST_END(ev[2]), .CTRL_RUN(run[0]),
        .BULK_HEAD(ev[3]), .BULK_TD_FOUND(ev[4]), .BULK_LIST_END(ev[5]), .BULK_RUN(run[1]),
        .OVERRUN(ev[6]), .OWNER_HANDOVER_DONE(ev[7]), .OWNER_CHANGE_FLAG(flag), .SYSTEM_MGMT_IRQ(system_mgmt_irq),
        .IRQ_ROUTING(rout), .FUNCTIONAL_STATE(fs), .HOST_BUS_ENABLE(hbe), .ROOT_HUB_RESET(rhr), .OPS_CLEAR(opc));
    // ==========================================================
    // helpers
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0);
        chk("prdata", e, host.rdata);
    endtask
    // one-cycle pulse, then settle to the falling edge before looking
    task automatic pulse(input int k);
        @(posedge clk);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev[k] <= 1'b0;
        @(negedge clk);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // watchdog, ten thousand cycles, far beyond the roughly 150 the tests need
    initial begin
        #40000;
        n_fail++;
        conclude;
    end
    // ==========================================================
    // tests
    initial begin
        repeat (7) @(posedge clk);
        @(negedge clk);
        chk("rhr", 32'h1, 32'(rhr));
        @(posedge clk);
        reset <= 1'b0;
        rdc(CMD_STATUS_OFF, 32'h0);
        chk("fstate", 32'h0, 32'(fs));
        host.xfer(1'b0, 8'h0C, 32'h0);
        chk("pslverr", 32'h1, 32'(host.err));
        $display("test reset done");
        // counter wraps and keeps counting with its flag already set
        for (int k = 1; k <= 5; k++) begin
            pulse(6);
            rdc(CMD_STATUS_OFF, 32'(k % 4) << OVR_CNT_LSB);
        end
        host.xfer(1'b1, CMD_STATUS_OFF, 32'h30000);
        rdc(CMD_STATUS_OFF, 32'h10000);
        $display("test overrun done");
        // control list then bulk list through the same walk
        for (int i = 0; i < 2; i++) begin
            b = 32'h2 << i;
            o = 3 * i;
            host.xfer(1'b1, CMD_STATUS_OFF, b);
            rdc(CMD_STATUS_OFF, b | 32'h10000);
            pulse(o);
            chk("run", 32'h1, 32'(run[i]));
            rdc(CMD_STATUS_OFF, 32'h10000);
            pulse(o + 1);
            rdc(CMD_STATUS_OFF, b | 32'h10000);
            pulse(o + 2);
            chk("run", 32'h1, 32'(run[i]));
            pulse(o);
            pulse(o + 2);
            chk("run", 32'h0, 32'(run[i]));
            pulse(o);
            chk("run", 32'h0, 32'(run[i]));
        end
        $display("test lists done");
        // ownership request with the event unmasked
        host.xfer(1'b1, CTRL_AUX_OFF, 32'hE);
        host.xfer(1'b1, CMD_STATUS_OFF, 32'h8);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("flag", 32'h1, 32'(flag));
        chk("smi", 32'h1, 32'(system_mgmt_irq));
        chk("hbe", 32'h1, 32'(hbe));
        pulse(7);
        rdc(CMD_STATUS_OFF, 32'h10000);
        rdc(EVT_STATUS_OFF, 32'h3);
        host.xfer(1'b1, EVT_STATUS_OFF, 32'h2);
        rdc(EVT_STATUS_OFF, 32'h1);
        $display("test ownership done");
        // soft reset from operational, routing set
        host.xfer(1'b1, CMD_STATUS_OFF, 32'h1);
        repeat (2) @(negedge clk);
        chk("fstate", 32'h3, 32'(fs));
        chk("hbe", 32'h0, 32'(hbe));
        chk("ops_clear", 32'h1, 32'(opc));
        chk("rhr", 32'h0, 32'(rhr));
        n = 0;
        do begin
            host.xfer(1'b0, CMD_STATUS_OFF, 32'h0);
            n++;
        end while (host.rdata[SOFT_RESET_BIT] === 1'b1 && n < 1300);
        chk("reset time", 32'h1, 32'(n * 3 < SOFT_RESET_LIMIT_CYCLES));
        rdc(CMD_STATUS_OFF, 32'h0);
        chk("routing", 32'h1, 32'(rout));
        chk("flag", 32'h0, 32'(flag));
        chk("ops_clear", 32'h0, 32'(opc));
        rdc(CTRL_AUX_OFF, 32'h7);
        rdc(EVT_STATUS_OFF, 32'h0);
        $display("test soft reset done");
        conclude;
    end
endmodule // tb_top
